// *** rtl/pwm_timer_pkg.sv ***
// Shared constants and carrier types for the PWM timer bank
`default_nettype none
package pwm_timer_pkg;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_PINS = 4;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  localparam int MUX_W = 4;
  localparam int DZ_W = 8;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [DZ_W-1:0] DZ_RESET = 8'h00;
  localparam logic [MUX_W-1:0] MUX_DIV2 = 4'h0;
  localparam logic [MUX_W-1:0] MUX_DIV4 = 4'h1;
  localparam logic [MUX_W-1:0] MUX_DIV8 = 4'h2;
  localparam logic [MUX_W-1:0] MUX_DIV16 = 4'h3;
  localparam logic [MUX_W-1:0] MUX_RESET = 4'h0;
  localparam int DIV_CNT_W = 4;

  // Per-timer control bits
  typedef struct packed {
    logic start;
    logic manual_update;
    logic inverter;
    logic auto_reload;
    logic irq_enable;
  } timer_control_reg_t;

  // Per-timer reload buffers
  typedef struct packed {
    logic [CNT_W-1:0] count_reload_buffer;
    logic [CNT_W-1:0] compare_reload_buffer;
  } reload_bufs_t;

  // Shared configuration: prescalers and dead-zone length
  typedef struct packed {
    logic [DZ_W-1:0] dead_zone_len;
    logic [PRE_W-1:0] prescale1;
    logic [PRE_W-1:0] prescale0;
  } timer_config_zero_t;
endpackage
`default_nettype wire

// *** rtl/tick_prescaler.sv ***
// Shared 8-bit prescaler with four-tap divider chain
`default_nettype none
module tick_prescaler
  import pwm_timer_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [pwm_timer_pkg::PRE_W-1:0] prescale_in,
  output logic [pwm_timer_pkg::DIV_CNT_W-1:0] div_tap_out
);
  logic [PRE_W-1:0] pre_cnt_r;
  logic [DIV_CNT_W-1:0] div_cnt_r;
  logic pre_tick;

  assign pre_tick = (pre_cnt_r == PRE_ZERO);

  // Divide by prescale value plus one
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pre_cnt_r <= PRE_ZERO;
    else if (pre_tick)
      pre_cnt_r <= prescale_in;
    else
      pre_cnt_r <= pre_cnt_r - PRE_ONE;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      div_cnt_r <= '0;
    else if (pre_tick)
      div_cnt_r <= div_cnt_r + {{(DIV_CNT_W-1){1'b0}}, 1'b1};
  end

  // One-cycle strobe per tap: bit k wraps every 2^(k+1) prescaler ticks
  genvar k;
  generate
    for (k = 0; k < DIV_CNT_W; k++)
    begin : g_tap
      assign div_tap_out[k] = pre_tick && (&div_cnt_r[k:0]);
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/timer_channel.sv ***
// One 16-bit down-counting timer with double-buffered reload and PWM level
`default_nettype none
module timer_channel
  import pwm_timer_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire pwm_timer_pkg::timer_control_reg_t ctrl_in,
  input wire pwm_timer_pkg::reload_bufs_t bufs_in,
  output logic [pwm_timer_pkg::CNT_W-1:0] down_counter_out,
  output logic [pwm_timer_pkg::CNT_W-1:0] compare_register_out,
  output logic level_out,
  output logic irq_out,
  output logic running_out
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cmp_r;
  logic [CNT_W-1:0] hold_r;
  logic [CNT_W-1:0] hold_cmp_r;
  logic reload_pend_r;
  logic level_r;
  logic irq_r;
  logic active;

  assign active = ctrl_in.start && !ctrl_in.manual_update;

  // Counter and compare register
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= CNT_RESET;
      cmp_r <= CNT_RESET;
    end
    else if (ctrl_in.manual_update)
    begin
      cnt_r <= bufs_in.count_reload_buffer;
      cmp_r <= bufs_in.compare_reload_buffer;
    end
    else if (active && tick_in)
    begin
      if (reload_pend_r)
      begin
        cnt_r <= hold_r;
        cmp_r <= hold_cmp_r;
      end
      else if (cnt_r != CNT_ZERO)
        cnt_r <= cnt_r - CNT_ONE;
    end
  end // Stopped timer holds value

  // Temporary holding register latched at zero
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hold_r <= CNT_RESET;
      hold_cmp_r <= CNT_RESET;
      reload_pend_r <= 1'b0;
    end
    else if (ctrl_in.manual_update || !ctrl_in.start)
      reload_pend_r <= 1'b0;
    else if (tick_in)
    begin
      if (reload_pend_r)
        reload_pend_r <= 1'b0;
      else if (cnt_r == CNT_ONE && ctrl_in.auto_reload)
      begin
        hold_r <= bufs_in.count_reload_buffer;
        hold_cmp_r <= bufs_in.compare_reload_buffer;
        reload_pend_r <= 1'b1;
      end
    end
  end

  // Output level: low at reload, high at compare match
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      level_r <= 1'b0;
    else if (ctrl_in.manual_update)
      level_r <= 1'b0;
    else if (active && tick_in)
    begin
      if (reload_pend_r)
        level_r <= 1'b0;
      else if (cnt_r != CNT_ZERO && (cnt_r - CNT_ONE) == cmp_r)
        level_r <= 1'b1;
    end
  end

  // One-cycle interrupt pulse when counter reaches zero
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      irq_r <= 1'b0;
    else
      irq_r <= active && tick_in && !reload_pend_r &&
        cnt_r == CNT_ONE && ctrl_in.irq_enable;
  end

  assign down_counter_out = cnt_r;
  assign compare_register_out = cmp_r;
  assign level_out = level_r;
  assign irq_out = irq_r;
  assign running_out = active && (cnt_r != CNT_ZERO || reload_pend_r);
endmodule
`default_nettype wire

// *** rtl/pwm_timer_bank.sv ***
// Five-timer PWM bank: prescalers, dividers, timers and output pins
//
// Summary of operation
// - Five timers, each a 16-bit down-counter decrementing per divided tick.
// - Timers 0-3 drive PWM pins; timer 4 is internal only.
// - Timers 0,1 share one 8-bit prescaler; timers 2,3,4 the other.
// - Per-timer divider picks 1/2, 1/4, 1/8, 1/16 or external tick.
// - At zero with auto-reload, reload counter and compare from buffers.
// - At zero without auto-reload, timer stops and stays at zero.
// - Reaching zero raises interrupt request if enabled.
// - At zero buffer latches to holding register; loads on next tick.
// - Clearing start holds counter value with no reload.
// - Output goes low to high when counter equals compare.
// - Reading count reload buffer returns stored reload, not live count.
// - Live counter is visible on a separate observe output.
// - Buffer writes during a run take effect only at next reload.
// - While manual update set, buffers copy into counter and compare.
// - Inverter bit inverts the pin on the next clock, running or not.
// - Counting begins within one tick period after start.
// - Tick rate is clock over prescale plus one over divider.
// - An 8-bit field holds dead-zone length in timer-0 ticks.
`default_nettype none
module pwm_timer_bank
  import pwm_timer_pkg::*;
#(
  parameter int TIMERS = NUM_TIMERS,
  parameter int PINS = NUM_PINS
)
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire pwm_timer_pkg::timer_config_zero_t timer_config_zero_in,
  input wire logic [TIMERS*pwm_timer_pkg::MUX_W-1:0] timer_config_one_in,
  input wire pwm_timer_pkg::timer_control_reg_t [TIMERS-1:0]
    timer_control_reg_in,
  input wire pwm_timer_pkg::reload_bufs_t [TIMERS-1:0] reload_bufs_in,
  input wire logic [TIMERS-1:0] external_tick_clock_in,
  output pwm_timer_pkg::reload_bufs_t [TIMERS-1:0] reload_bufs_rd_out,
  output logic [TIMERS*pwm_timer_pkg::CNT_W-1:0] count_observe_reg_out,
  output logic [pwm_timer_pkg::DZ_W-1:0] dead_zone_len_out,
  output logic [PINS-1:0] pwm_output_pin_out,
  output logic [TIMERS-1:0] irq_out,
  output logic [TIMERS-1:0] running_out
);
  // --------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------
  // Shared configuration registers
  // --------------------------------------------------------------
  logic [PRE_W-1:0] prescale0_r;
  logic [PRE_W-1:0] prescale1_r;
  logic [DZ_W-1:0] dead_zone_r;

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prescale0_r <= PRE_RESET;
      prescale1_r <= PRE_RESET;
      dead_zone_r <= DZ_RESET;
    end
    else
    begin
      prescale0_r <= timer_config_zero_in.prescale0;
      prescale1_r <= timer_config_zero_in.prescale1;
      dead_zone_r <= timer_config_zero_in.dead_zone_len;
    end
  end

  assign dead_zone_len_out = dead_zone_r;

  // --------------------------------------------------------------
  // Prescalers
  // --------------------------------------------------------------
  logic [DIV_CNT_W-1:0] taps0;
  logic [DIV_CNT_W-1:0] taps1;

  // Timers 0 and 1
  tick_prescaler u_pre0 (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_r),
    .prescale_in(prescale0_r),
    .div_tap_out(taps0)
  );

  // Timers 2, 3 and 4
  tick_prescaler u_pre1 (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_r),
    .prescale_in(prescale1_r),
    .div_tap_out(taps1)
  );

  // --------------------------------------------------------------
  // Per-timer divider select, external tick and timer
  // --------------------------------------------------------------
  logic [TIMERS-1:0] ext_meta_r;
  logic [TIMERS-1:0] ext_sync_r;
  logic [TIMERS-1:0] ext_prev_r;
  logic [TIMERS-1:0] tick;
  logic [TIMERS-1:0] level;
  logic [TIMERS-1:0] irq;
  logic [TIMERS-1:0] run;
  logic [TIMERS*CNT_W-1:0] cnt_flat;
  logic [TIMERS*CNT_W-1:0] cmp_flat;

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ext_meta_r <= '0;
      ext_sync_r <= '0;
      ext_prev_r <= '0;
    end
    else
    begin
      ext_meta_r <= external_tick_clock_in;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  genvar t;
  generate
    for (t = 0; t < TIMERS; t++)
    begin : g_timer
      logic [MUX_W-1:0] sel;
      logic [DIV_CNT_W-1:0] taps;

      assign sel = timer_config_one_in[t*MUX_W +: MUX_W];
      assign taps = (t < 2) ? taps0 : taps1;

      // Five-way source select
      always_comb
      begin
        unique case (sel)
          MUX_DIV2: tick[t] = taps[0];
          MUX_DIV4: tick[t] = taps[1];
          MUX_DIV8: tick[t] = taps[2];
          MUX_DIV16: tick[t] = taps[3];
          default: tick[t] = ext_sync_r[t] && !ext_prev_r[t];
        endcase
      end

      timer_channel u_chan (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_r),
        .tick_in(tick[t]),
        .ctrl_in(timer_control_reg_in[t]),
        .bufs_in(reload_bufs_in[t]),
        .down_counter_out(cnt_flat[t*CNT_W +: CNT_W]),
        .compare_register_out(cmp_flat[t*CNT_W +: CNT_W]),
        .level_out(level[t]),
        .irq_out(irq[t]),
        .running_out(run[t])
      );

      assign reload_bufs_rd_out[t] = reload_bufs_in[t];
    end
  endgenerate

  assign count_observe_reg_out = cnt_flat;
  assign irq_out = irq;
  assign running_out = run;

  // --------------------------------------------------------------
  // Output pins with inverter
  // --------------------------------------------------------------
  logic [PINS-1:0] pin_r;
  logic [PINS-1:0] pin_nxt;

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      pin_r <= '0;
    else
      pin_r <= pin_nxt;
  end

  genvar p;
  generate
    for (p = 0; p < PINS; p++)
    begin : g_pin
      // Inversion reaches the pin on the next clock
      assign pin_nxt[p] = level[p] ^ timer_control_reg_in[p].inverter;
    end
  endgenerate

  assign pwm_output_pin_out = pin_r;

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_irq_at_zero;
    @(posedge mclk_in) disable iff (!rst_n_r)
    irq[0] |-> $past(timer_control_reg_in[0].irq_enable) &&
      cnt_flat[CNT_W-1:0] == CNT_ZERO;
  endproperty
  a_irq_at_zero: assert property (p_irq_at_zero)
    else $error("interrupt without enabled zero");

  property p_dec;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (tick[0] && timer_control_reg_in[0].start &&
      !timer_control_reg_in[0].manual_update &&
      cnt_flat[CNT_W-1:0] > CNT_ONE) ##1 !$past(timer_control_reg_in[0].manual_update)
      |-> cnt_flat[CNT_W-1:0] == $past(cnt_flat[CNT_W-1:0]) - CNT_ONE;
  endproperty
  a_dec: assert property (p_dec)
    else $error("counter failed to decrement");

  property p_hold_stop;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (!timer_control_reg_in[0].start && !timer_control_reg_in[0].manual_update)
      |=> $stable(cnt_flat[CNT_W-1:0]) ||
        $past(timer_control_reg_in[0].manual_update);
  endproperty
  a_hold_stop: assert property (p_hold_stop)
    else $error("stopped counter changed");

  property p_manual;
    @(posedge mclk_in) disable iff (!rst_n_r)
    timer_control_reg_in[0].manual_update |=>
      cnt_flat[CNT_W-1:0] == $past(reload_bufs_in[0].count_reload_buffer);
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual update not applied");

  property p_stop_zero;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (cnt_flat[CNT_W-1:0] == CNT_ZERO && !run[0] &&
      !timer_control_reg_in[0].manual_update)
      |=> cnt_flat[CNT_W-1:0] == CNT_ZERO;
  endproperty
  a_stop_zero: assert property (p_stop_zero)
    else $error("stopped timer left zero");

  property p_inv;
    @(posedge mclk_in) disable iff (!rst_n_r)
    ($changed(timer_control_reg_in[1].inverter) && $stable(level[1])) |=>
      pwm_output_pin_out[1] != $past(pwm_output_pin_out[1]);
  endproperty
  a_inv: assert property (p_inv)
    else $error("pin does not follow inverter");

  property p_tick_div2;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (timer_config_one_in[MUX_W-1:0] == MUX_DIV2 && prescale0_r == PRE_ZERO
      && tick[0]) ##1 (timer_config_one_in[MUX_W-1:0] == MUX_DIV2 &&
      prescale0_r == PRE_ZERO) |-> ##1 tick[0];
  endproperty
  a_tick_div2: assert property (p_tick_div2)
    else $error("divide by two tick spacing wrong");

  property p_dz;
    @(posedge mclk_in) disable iff (!rst_n_r)
    1'b1 |=> dead_zone_len_out == $past(timer_config_zero_in.dead_zone_len);
  endproperty
  a_dz: assert property (p_dz)
    else $error("dead zone length not captured");

  // Count buffer captured as timer 0 reaches zero
  logic [CNT_W-1:0] zero_buf_r;

  always_ff @(posedge mclk_in or negedge rst_n_r)
  begin
    if (!rst_n_r)
      zero_buf_r <= CNT_RESET;
    else if (tick[0] && run[0] && cnt_flat[CNT_W-1:0] == CNT_ONE)
      zero_buf_r <= reload_bufs_in[0].count_reload_buffer;
  end

  property p_reload;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (tick[0] && run[0] && cnt_flat[CNT_W-1:0] == CNT_ZERO)
      |=> cnt_flat[CNT_W-1:0] == zero_buf_r;
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not use latched buffer");

  property p_low_at_reload;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (tick[0] && run[0] && cnt_flat[CNT_W-1:0] == CNT_ZERO) |=> !level[0];
  endproperty
  a_low_at_reload: assert property (p_low_at_reload)
    else $error("level not low after reload");

  property p_rise_at_match;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (tick[0] && run[0] && cnt_flat[CNT_W-1:0] != CNT_ZERO &&
      cnt_flat[CNT_W-1:0] - CNT_ONE == cmp_flat[CNT_W-1:0])
      |=> level[0];
  endproperty
  a_rise_at_match: assert property (p_rise_at_match)
    else $error("level not high at compare match");

  property p_cmp_stable;
    @(posedge mclk_in) disable iff (!rst_n_r)
    (!timer_control_reg_in[0].manual_update &&
      cnt_flat[CNT_W-1:0] != CNT_ZERO) |=> $stable(cmp_flat[CNT_W-1:0]);
  endproperty
  a_cmp_stable: assert property (p_cmp_stable)
    else $error("compare register changed mid period");

  property p_irq_pulse;
    @(posedge mclk_in) disable iff (!rst_n_r)
    irq[0] |=> !irq[0];
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt pulse longer than one cycle");

  c_irq: cover property (@(posedge mclk_in) disable iff (!rst_n_r) irq[0]);
  c_high: cover property (@(posedge mclk_in) disable iff (!rst_n_r)
    $rose(level[1]));
  c_ext: cover property (@(posedge mclk_in) disable iff (!rst_n_r)
    tick[4] && timer_config_one_in[4*MUX_W +: MUX_W] == 4'h4);
  c_reload: cover property (@(posedge mclk_in) disable iff (!rst_n_r)
    tick[0] && run[0] && cnt_flat[CNT_W-1:0] == CNT_ZERO);
  c_oneshot: cover property (@(posedge mclk_in) disable iff (!rst_n_r)
    cnt_flat[2*CNT_W-1:CNT_W] == CNT_ZERO && pwm_output_pin_out[1]);
endmodule
`default_nettype wire

// *** sim/pwm_load_model.sv ***
// Far-side model: loads on the PWM pins and an external tick source
`default_nettype none
module pwm_load_model
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] pin_in,
  input wire logic tick_en_in,
  output logic [4:0] ext_tick_out,
  output logic [31:0] rises_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] pin_r;
  logic [1:0] div_r;
  logic tick_r;

  // ------------------------------
  // Rising edges seen by each load
  // ------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_r <= 4'h0;
      rises_out <= 32'h0;
    end
    else
    begin
      pin_r <= pin_in;
      for (int i = 0; i < 4; i++)
        if (pin_in[i] && !pin_r[i])
          rises_out[8*i +: 8] <= rises_out[8*i +: 8] + 8'h01;
    end
  end

  // ------------------------------
  // Tick clock, rising every 6 cycles, parked low when off
  // ------------------------------
  always_ff @(posedge mclk_in)
  begin
    if (!tick_en_in)
    begin
      div_r <= 2'h0;
      tick_r <= 1'b0;
    end
    else if (div_r == 2'h2)
    begin
      div_r <= 2'h0;
      tick_r <= !tick_r;
    end
    else
      div_r <= div_r + 2'h1;
  end
  assign ext_tick_out = {5{tick_r}};
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the PWM timer bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pwm_timer_pkg::*;
  timer_config_zero_t cfg0;
  logic [19:0] cfg1;
  timer_control_reg_t [4:0] ctrl;
  reload_bufs_t [4:0] bufs;
  reload_bufs_t [4:0] rd;
  logic [4:0] ext, irq, run;
  logic [79:0] obs;
  logic [7:0] dz;
  logic [3:0] pins;
  logic [31:0] rises;
  logic mclk, arst_n, tick_en;
  int miscompares, checks_done, irq_seen;

  pwm_timer_bank DUT (.mclk_in(mclk), .arst_n_in(arst_n),
    .timer_config_zero_in(cfg0), .timer_config_one_in(cfg1),
    .timer_control_reg_in(ctrl), .reload_bufs_in(bufs),
    .external_tick_clock_in(ext), .reload_bufs_rd_out(rd),
    .count_observe_reg_out(obs), .dead_zone_len_out(dz),
    .pwm_output_pin_out(pins), .irq_out(irq), .running_out(run));
  pwm_load_model load (.mclk_in(mclk), .rst_n_in(arst_n), .pin_in(pins),
    .tick_en_in(tick_en), .ext_tick_out(ext), .rises_out(rises));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = !mclk;
  end

  // ------------------------------
  // Shared helpers
  // ------------------------------
  function automatic logic [15:0] cnt(input int t);
    return obs[16*t +: 16];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wait_val(input int t, input logic [15:0] v, output int n);
    n = 0;
    while (cnt(t) !== v && n < 3000)
    begin
      if (irq[t] === 1'b1)
        irq_seen++;
      cyc(1);
      n++;
    end
    if (n == 3000)
    begin
      check(cnt(t), v);
      close_out();
    end
  endtask

  // Cycles between the second and third counter change
  task automatic gap(input int t, output int g);
    logic [15:0] v;
    for (int k = 0; k < 3; k++)
    begin
      v = cnt(t);
      g = 0;
      while (cnt(t) === v && g < 100)
      begin
        cyc(1);
        g++;
      end
      if (g == 100)
      begin
        check(cnt(t), ~v);
        close_out();
      end
    end
  endtask

  task automatic prep(input int t, input logic [15:0] n, input logic [15:0] c,
                      input logic ar, input logic ie);
    bufs[t] = '{n, c};
    ctrl[t] = '{1'b0, 1'b1, 1'b0, ar, ie};
    cyc(2);
    check(cnt(t), n);
    check(run[t], 1'b0);
    ctrl[t].start = 1'b1;
    ctrl[t].manual_update = 1'b0;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_reset();
    check(obs, 80'h0);
    check({irq, pins, run}, 14'h0);
    check(dz, 8'h5a);
    $display("test reset done");
  endtask

  task automatic t_period();
    int n, i;
    logic [15:0] v;
    prep(0, 16'h000c, 16'h0005, 1'b1, 1'b1);
    v = cnt(0);
    i = 0;
    while (cnt(0) === v && i < 6)
    begin
      cyc(1);
      i++;
    end
    check(i <= 4, 1'b1);
    check(cnt(0), v - 16'h1);
    gap(0, n);
    check(n, 2);
    bufs[0] = '{16'h0014, 16'h0008};
    cyc(1);
    check(rd[0], {16'h0014, 16'h0008});
    wait_val(0, 16'h0006, n);
    check(pins[0], 1'b0);
    wait_val(0, 16'h0005, n);
    cyc(1);
    check(pins[0], 1'b1);
    i = irq_seen;
    wait_val(0, 16'h0014, n);
    check(irq_seen - i, 1);
    check(n <= 14, 1'b1);
    cyc(1);
    check(pins[0], 1'b0);
    wait_val(0, 16'h0009, n);
    check(pins[0], 1'b0);
    wait_val(0, 16'h0008, n);
    cyc(1);
    check(pins[0], 1'b1);
    $display("test period done");
  endtask

  task automatic t_stop();
    logic [15:0] v;
    ctrl[0].start = 1'b0;
    cyc(2);
    v = cnt(0);
    cyc(20);
    check(cnt(0), v);
    check(run[0], 1'b0);
    $display("test stop done");
  endtask

  task automatic t_oneshot();
    int n, i;
    logic [7:0] r;
    r = rises[15:8];
    prep(1, 16'h0004, 16'h0002, 1'b0, 1'b0);
    i = irq_seen;
    wait_val(1, 16'h0000, n);
    cyc(20);
    check(irq_seen - i, 0);
    check(cnt(1), 16'h0);
    check(pins[1], 1'b1);
    check(rises[15:8], r + 8'h1);
    ctrl[1].inverter = 1'b1;
    cyc(2);
    check(pins[1], 1'b0);
    ctrl[1].inverter = 1'b0;
    cyc(2);
    check(pins[1], 1'b1);
    $display("test oneshot done");
  endtask

  task automatic t_divider();
    int g;
    cfg0.prescale1 = 8'h01;
    cfg0.prescale0 = 8'h03;
    prep(2, 16'hff00, 16'h0010, 1'b1, 1'b0);
    for (int c = 0; c < 4; c++)
    begin
      cfg1[11:8] = c[3:0];
      gap(2, g);
      check(g, 2 * (2 << c));
    end
    prep(0, 16'hff00, 16'h0010, 1'b1, 1'b0);
    gap(0, g);
    check(g, 8);
    cfg1[19:16] = MUX_DIV4;
    prep(4, 16'hff00, 16'h0010, 1'b1, 1'b0);
    gap(4, g);
    check(g, 8);
    tick_en = 1'b1;
    cfg1[15:12] = 4'h4;
    prep(3, 16'hff00, 16'h0010, 1'b1, 1'b0);
    gap(3, g);
    check(g, 6);
    $display("test divider done");
  endtask

  initial
  begin
    arst_n = 1'b0;
    tick_en = 1'b0;
    cfg0 = '{8'h5a, PRE_ZERO, PRE_ZERO};
    cfg1 = 20'h0;
    ctrl = '0;
    bufs = '0;
    miscompares = 0;
    checks_done = 0;
    irq_seen = 0;
    cyc(12);
    arst_n = 1'b1;
    cyc(4);
    t_reset();
    t_period();
    t_stop();
    t_oneshot();
    t_divider();
    close_out();
  end
endmodule
`default_nettype wire
